/* rtl/quad_switch_spi_command_decoder.sv */
// Command decoder and configuration register bank of a four-output high-side switch
`timescale 1ns/1ps
// Function
// - Commands are decoded only as complete sixteen-bit words.
// - Bits 14:13 pick the output for per-output registers.
// - Bits 12:10 pick the destination register.
// - Bits 8:0 carry register data or readout selection.
// - Frames not a multiple of sixteen bits are discarded entirely.
// - Back-to-back words in one select period are allowed.
// - Select codes: status, duty, switching, fault, overcurrent, global, calibration.
// - All writable registers clear on reset; all but the watchdog toggle bit also clear on logic supply failure with its enable set, power-on.
// - In normal mode overtemperature warning sets the prewarning flag.
// - Prewarning flag holds until a readout command retrieves it.
// - Battery clamp cancels overload turn-off and switches all outputs on unless ground is lost.
// - Logic supply loss with its enable set wipes all registers except the watchdog toggle bit.
// - Without logic supply outputs follow the direct input pins.
// - Without logic supply protection uses all-zero configuration defaults.
// - Battery loss keeps configuration and serial features working.
// - Battery loss is reported as an undervoltage flag.
// - Power-on of both supplies clears registers and latched faults.
// - Ground disconnect turns the outputs off unconditionally.
// - Readout bits 4:0 select the returned status content.
// - Output-select codes 00 to 11 map to outputs zero to three.
module quad_switch_spi_command_decoder
	import switch_cmd_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_si,
	input wire logic [switch_cmd_pkg::NUM_OUT-1:0] i_direct_in,
	input wire logic [switch_cmd_pkg::NUM_OUT-1:0] i_overload_off,
	input wire switch_cmd_pkg::supply_t i_supply,
	output logic [switch_cmd_pkg::NUM_OUT-1:0] o_switched_outputs,
	output logic [switch_cmd_pkg::NUM_OUT-1:0][switch_cmd_pkg::DATA_BITS-1:0] o_duty_cfg,
	output logic [switch_cmd_pkg::NUM_OUT-1:0][switch_cmd_pkg::DATA_BITS-1:0] o_switching_cfg,
	output logic [switch_cmd_pkg::NUM_OUT-1:0][switch_cmd_pkg::DATA_BITS-1:0] o_fault_cfg,
	output logic [switch_cmd_pkg::NUM_OUT-1:0][switch_cmd_pkg::DATA_BITS-1:0] o_overcurrent_cfg,
	output logic [switch_cmd_pkg::DATA_BITS-1:0] o_global_cfg,
	output logic [switch_cmd_pkg::DATA_BITS-1:0] o_calibration_cfg,
	output logic [switch_cmd_pkg::DATA_BITS-1:0] o_readout_select,
	output logic o_readout_strobe,
	output logic o_watchdog_toggle_bit,
	output logic o_temp_prewarn_flag,
	output logic o_undervoltage_flag
);
	// ==================================================================
	// Declarations
	command_t word;
	logic word_valid, frame_bad;
	supply_t sup_meta, sup;
	logic [NUM_OUT-1:0] dir_meta, dir_sync;
	logic [NUM_OUT-1:0][DATA_BITS-1:0] output_duty_control, next_duty;
	logic [NUM_OUT-1:0][DATA_BITS-1:0] output_switching_config, next_switching;
	logic [NUM_OUT-1:0][DATA_BITS-1:0] output_fault_config, next_fault;
	logic [NUM_OUT-1:0][DATA_BITS-1:0] output_overcurrent_config, next_overcurrent;
	logic [DATA_BITS-1:0] global_config, next_global;
	logic [DATA_BITS-1:0] calibration_trigger, next_calibration;
	logic [DATA_BITS-1:0] status_readout_select, next_readout;
	logic next_readout_strobe, next_watchdog;
	logic [NUM_OUT-1:0] next_outputs;
	logic wipe, logic_down, prewarn_clear, uv_clear;
	logic [NUM_OUT-1:0][DATA_BITS-1:0] next_duty_out, next_switching_out;
	logic [NUM_OUT-1:0][DATA_BITS-1:0] next_fault_out, next_overcurrent_out;

	// True for a write that addresses one of the global registers
	function automatic logic global_hit(input command_t c, input logic [2:0] sel);
		global_hit = (c.reg_select == sel) && (c.output_select == GLOBAL_OUTPUT_SELECT);
	endfunction : global_hit

	// ==================================================================
	// Serial front end
	spi_word_receiver u_receiver (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_sclk(i_sclk),
		.i_cs_n(i_cs_n),
		.i_si(i_si),
		.o_word(word),
		.o_word_valid(word_valid),
		.o_frame_bad(frame_bad)
	);

	// Pin-level supply monitors and direct inputs come from outside the clock domain
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			sup_meta <= SUPPLY_RESET;
			sup <= SUPPLY_RESET;
			dir_meta <= '0;
			dir_sync <= '0;
		end else begin
			sup_meta <= i_supply;
			sup <= sup_meta;
			dir_meta <= i_direct_in;
			dir_sync <= dir_meta;
		end
	end

	// Register wipe; the enable bit gates only the logic supply case
	assign logic_down = sup.logic_supply_fail;
	assign wipe = (logic_down & global_config[VDD_FAIL_EN_BIT]) | sup.both_supply_por;

	// ==================================================================
	// Register write decode, applied only on a whole word at frame end
	always_comb begin
		next_duty = output_duty_control;
		next_switching = output_switching_config;
		next_fault = output_fault_config;
		next_overcurrent = output_overcurrent_config;
		next_global = global_config;
		next_calibration = calibration_trigger;
		next_readout = status_readout_select;
		next_readout_strobe = 1'b0;
		next_watchdog = o_watchdog_toggle_bit;
		if (word_valid) begin
			next_watchdog = word.watchdog_toggle_bit;
			// Bit 9 is not looked at anywhere
			unique case (word.reg_select)
				SEL_STATUS: begin
					next_readout = word.data;
					next_readout_strobe = 1'b1;
				end
				SEL_DUTY: next_duty[word.output_select] = word.data;
				SEL_SWITCH: next_switching[word.output_select] = word.data;
				SEL_FAULT: next_fault[word.output_select] = word.data;
				SEL_OVERCURRENT: next_overcurrent[word.output_select] = word.data;
				SEL_GLOBAL: begin
					if (global_hit(word, SEL_GLOBAL)) begin
						next_global = word.data;
					end
				end
				SEL_CAL: begin
					// Content is trusted; the host owns the fixed pattern
					if (global_hit(word, SEL_CAL)) begin
						next_calibration = word.data;
					end
				end
				default: begin
				end
			endcase
		end
		if (wipe) begin
			next_duty = '0;
			next_switching = '0;
			next_fault = '0;
			next_overcurrent = '0;
			next_global = REG_RESET;
			next_calibration = REG_RESET;
			next_readout = REG_RESET;
		end
	end

	// ==================================================================
	// Output drive; ground loss outranks the clamp, clamp outranks overload
	always_comb begin
		for (int i = 0; i < NUM_OUT; i++) begin
			if (logic_down) begin
				next_outputs[i] = dir_sync[i] & ~i_overload_off[i];
			end else begin
				next_outputs[i] = (output_duty_control[i][DUTY_ON_BIT]
					| (dir_sync[i] & ~output_switching_config[i][DIR_DISABLE_BIT]))
					& ~i_overload_off[i];
			end
			if (sup.battery_clamp) begin
				next_outputs[i] = 1'b1;
			end
			if (sup.ground_lost) begin
				next_outputs[i] = 1'b0;
			end
		end
	end

	// Protection sees all-zero defaults while the logic supply is gone
	always_comb begin
		next_duty_out = logic_down ? '0 : output_duty_control;
		next_switching_out = logic_down ? '0 : output_switching_config;
		next_fault_out = logic_down ? '0 : output_fault_config;
		next_overcurrent_out = logic_down ? '0 : output_overcurrent_config;
	end

	// Register bank and registered outputs
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			output_duty_control <= '0;
			output_switching_config <= '0;
			output_fault_config <= '0;
			output_overcurrent_config <= '0;
			global_config <= REG_RESET;
			calibration_trigger <= REG_RESET;
			status_readout_select <= REG_RESET;
			o_readout_strobe <= 1'b0;
			o_watchdog_toggle_bit <= 1'b0;
			o_switched_outputs <= '0;
			o_duty_cfg <= '0;
			o_switching_cfg <= '0;
			o_fault_cfg <= '0;
			o_overcurrent_cfg <= '0;
		end else begin
			output_duty_control <= next_duty;
			output_switching_config <= next_switching;
			output_fault_config <= next_fault;
			output_overcurrent_config <= next_overcurrent;
			global_config <= next_global;
			calibration_trigger <= next_calibration;
			status_readout_select <= next_readout;
			o_readout_strobe <= next_readout_strobe;
			o_watchdog_toggle_bit <= next_watchdog;
			o_switched_outputs <= next_outputs;
			o_duty_cfg <= next_duty_out;
			o_switching_cfg <= next_switching_out;
			o_fault_cfg <= next_fault_out;
			o_overcurrent_cfg <= next_overcurrent_out;
		end
	end

	assign o_global_cfg = global_config;
	assign o_calibration_cfg = calibration_trigger;
	assign o_readout_select = status_readout_select;

	// ==================================================================
	// Diagnostic flags; a read that races a new event leaves it set
	assign prewarn_clear = word_valid && word.reg_select == SEL_STATUS
		&& word.data[READOUT_BITS-1:0] == READOUT_DIAG0;
	assign uv_clear = word_valid && word.reg_select == SEL_STATUS && !word.data[READOUT_BIT4];

	sticky_flag u_prewarn (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_wipe(wipe),
		.i_set(sup.overtemp_warn & ~logic_down),
		.i_clear(prewarn_clear),
		.o_flag(o_temp_prewarn_flag)
	);

	sticky_flag u_undervoltage (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_wipe(wipe),
		.i_set(sup.battery_lost),
		.i_clear(uv_clear),
		.o_flag(o_undervoltage_flag)
	);

	// ==================================================================
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	a_ground_off: assert property (sup.ground_lost |=> o_switched_outputs == '0)
		else $error("outputs not off on ground loss");
	a_clamp_all_on: assert property (sup.battery_clamp && !sup.ground_lost |=> &o_switched_outputs)
		else $error("clamp did not switch all outputs on");
	a_bad_frame_hold: assert property (frame_bad && !wipe |=> $stable(output_duty_control) && $stable(global_config))
		else $error("discarded frame changed a register");
	a_write_at_end: assert property (!word_valid && !wipe |=> $stable(output_fault_config))
		else $error("register changed without a finished word");
	a_duty_target: assert property (word_valid && word.reg_select == SEL_DUTY && !wipe
		|=> output_duty_control[$past(word.output_select)] == $past(word.data))
		else $error("duty word landed in wrong output");
	a_global_decode: assert property (word_valid && global_hit(word, SEL_GLOBAL) && !wipe
		|=> global_config == $past(word.data))
		else $error("global register write lost");
	a_wipe_zero: assert property (wipe |=> global_config == REG_RESET && output_duty_control == '0)
		else $error("wipe left register data");
	a_prewarn_hold: assert property (o_temp_prewarn_flag && !prewarn_clear && !wipe |=> o_temp_prewarn_flag)
		else $error("prewarning flag dropped without a read");
	a_prewarn_set: assert property (sup.overtemp_warn && !logic_down && !wipe |=> o_temp_prewarn_flag)
		else $error("prewarning not latched");
	a_uv_report: assert property (sup.battery_lost && !wipe |=> o_undervoltage_flag)
		else $error("battery loss not reported");
	a_retain_cfg: assert property (sup.battery_lost && !word_valid && !wipe |=> $stable(output_switching_config))
		else $error("battery loss disturbed configuration");
	a_direct_follow: assert property (logic_down && !sup.battery_clamp && !sup.ground_lost
		&& !i_overload_off[0] |=> o_switched_outputs[0] == $past(dir_sync[0]))
		else $error("output does not follow direct input");
	a_defaults_out: assert property (logic_down |=> o_fault_cfg == '0 && o_duty_cfg == '0)
		else $error("non-default configuration without logic supply");

	// Readout strobe, watchdog copy and per-output targets
	a_strobe_pulse: assert property (word_valid && word.reg_select == SEL_STATUS && !wipe
		|=> o_readout_strobe && status_readout_select == $past(word.data))
		else $error("status readout word not taken");
	a_strobe_idle: assert property (!word_valid |=> !o_readout_strobe)
		else $error("readout strobe without a word");
	a_watchdog_copy: assert property (word_valid
		|=> o_watchdog_toggle_bit == $past(word.watchdog_toggle_bit))
		else $error("watchdog bit not taken from word");
	a_switch_target: assert property (word_valid && word.reg_select == SEL_SWITCH && !wipe
		|=> output_switching_config[$past(word.output_select)] == $past(word.data))
		else $error("switching word landed in wrong output");
	a_overcurrent_target: assert property (word_valid && word.reg_select == SEL_OVERCURRENT && !wipe
		|=> output_overcurrent_config[$past(word.output_select)] == $past(word.data))
		else $error("overcurrent word landed in wrong output");
	c_duty_write: cover property (word_valid && word.reg_select == SEL_DUTY);
	c_prewarn_read: cover property (o_temp_prewarn_flag ##1 prewarn_clear);
	c_clamp_event: cover property (sup.battery_clamp && |i_overload_off);
endmodule : quad_switch_spi_command_decoder

/* rtl/switch_cmd_pkg.sv */
// Shared constants, command layout and supply flags of the serial command decoder
package switch_cmd_pkg;
	// ==================================================================
	// Word format
	localparam int WORD_BITS = 16;
	localparam int DATA_BITS = 9;
	localparam int NUM_OUT = 4;
	localparam int COUNT_BITS = 4;
	localparam int READOUT_BITS = 5;

	// Command word as shifted in, bit 15 first
	typedef struct packed {
		logic watchdog_toggle_bit;
		logic [1:0] output_select;
		logic [2:0] reg_select;
		logic unused_bit;
		logic [DATA_BITS-1:0] data;
	} command_t;

	// ==================================================================
	// Register select codes
	localparam logic [2:0] SEL_STATUS = 3'h0;
	localparam logic [2:0] SEL_DUTY = 3'h1;
	localparam logic [2:0] SEL_SWITCH = 3'h2;
	localparam logic [2:0] SEL_FAULT = 3'h3;
	localparam logic [2:0] SEL_OVERCURRENT = 3'h4;
	localparam logic [2:0] SEL_GLOBAL = 3'h5;
	localparam logic [2:0] SEL_CAL = 3'h7;
	localparam logic [1:0] GLOBAL_OUTPUT_SELECT = 2'h0;

	// ==================================================================
	// Reset values and field positions
	localparam logic [DATA_BITS-1:0] REG_RESET = 9'h000;
	localparam logic [COUNT_BITS-1:0] COUNT_ZERO = 4'h0;
	localparam logic [COUNT_BITS-1:0] COUNT_ONE = 4'h1;
	localparam int DUTY_PROFILE_BIT = 8;
	localparam int DUTY_ON_BIT = 7;
	localparam int DUTY_VALUE_MSB = 6;
	localparam int DIR_DISABLE_BIT = 5;
	localparam int VDD_FAIL_EN_BIT = 8;
	localparam int READOUT_BIT4 = 4;
	localparam logic [READOUT_BITS-1:0] READOUT_DIAG0 = 5'h01;

	// Supply and environment conditions seen at the pins
	typedef struct packed {
		logic logic_supply_fail;
		logic both_supply_por;
		logic battery_lost;
		logic battery_clamp;
		logic ground_lost;
		logic overtemp_warn;
	} supply_t;
	localparam supply_t SUPPLY_RESET = '0;
endpackage : switch_cmd_pkg

/* rtl/sticky_flag.sv */
// Latched diagnostic flag, set wins over clear
`timescale 1ns/1ps
module sticky_flag (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_wipe,
	input wire logic i_set,
	input wire logic i_clear,
	output logic o_flag
);
	logic next_flag;

	// ==================================================================
	// Next value: an event in the clearing cycle is kept
	always_comb begin
		next_flag = i_set | (o_flag & ~i_clear);
		if (i_wipe) begin
			next_flag = 1'b0;
		end
	end

	// Register
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_flag <= 1'b0;
		end else begin
			o_flag <= next_flag;
		end
	end
endmodule : sticky_flag

/* rtl/spi_word_receiver.sv */
// Oversampled serial input shifter that delivers whole 16-bit words at frame end
`timescale 1ns/1ps
module spi_word_receiver
	import switch_cmd_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_si,
	output switch_cmd_pkg::command_t o_word,
	output logic o_word_valid,
	output logic o_frame_bad
);
	// Two-flop synchronisers plus one history stage for edges
	logic [2:0] sync1, sync2, hist;
	logic [WORD_BITS-1:0] shift, next_shift;
	logic [COUNT_BITS-1:0] count, next_count;
	logic any_bits, next_any_bits;
	logic next_word_valid, next_frame_bad;
	command_t next_word;
	logic sclk_rise, cs_rise, cs_low;

	assign sclk_rise = sync2[2] & ~hist[2];
	assign cs_rise = sync2[1] & ~hist[1];
	assign cs_low = ~sync2[1];

	// ==================================================================
	// Shift MSB first, count modulo one word
	always_comb begin
		next_shift = shift;
		next_count = count;
		next_any_bits = any_bits;
		next_word = o_word;
		next_word_valid = 1'b0;
		next_frame_bad = 1'b0;
		if (cs_low && sclk_rise) begin
			next_shift = {shift[WORD_BITS-2:0], sync2[0]};
			next_count = count + COUNT_ONE;
			next_any_bits = 1'b1;
		end
		if (cs_rise) begin
			// Only the last whole word is kept; earlier ones are shifted out and dropped
			if (any_bits && count == COUNT_ZERO) begin
				next_word = command_t'(shift);
				next_word_valid = 1'b1;
			end else if (any_bits) begin
				next_frame_bad = 1'b1;
			end
			next_count = COUNT_ZERO;
			next_any_bits = 1'b0;
		end
	end

	// Register
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			sync1 <= 3'h2;
			sync2 <= 3'h2;
			hist <= 3'h2;
			shift <= '0;
			count <= COUNT_ZERO;
			any_bits <= 1'b0;
			o_word <= '0;
			o_word_valid <= 1'b0;
			o_frame_bad <= 1'b0;
		end else begin
			sync1 <= {i_sclk, i_cs_n, i_si};
			sync2 <= sync1;
			hist <= sync2;
			shift <= next_shift;
			count <= next_count;
			any_bits <= next_any_bits;
			o_word <= next_word;
			o_word_valid <= next_word_valid;
			o_frame_bad <= next_frame_bad;
		end
	end

	// ==================================================================
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	a_whole_word_only: assert property (cs_rise && any_bits |=> o_word_valid == $past(count == COUNT_ZERO))
		else $error("word delivery does not match bit count");
	a_odd_frame_flag: assert property (cs_rise && any_bits && count != COUNT_ZERO |=> o_frame_bad && !o_word_valid)
		else $error("odd length frame not refused");
	c_word_taken: cover property (o_word_valid);
	c_frame_refused: cover property (o_frame_bad);
endmodule : spi_word_receiver

/* tb/spi_host_model.sv */
// Host-side serial master that shifts command frames into the decoder
`timescale 1ns/1ps
module spi_host_model (
	input wire logic i_clock,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_si
);
	// ==========================================
	// Idle levels: clock low, select released
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end

	// ==========================================
	// One frame of n bits, top bit first, four clocks per phase
	task automatic send(input logic [31:0] bits, input int n);
		@(posedge i_clock);
		o_cs_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_si <= bits[i];
			repeat (4) @(posedge i_clock);
			o_sclk <= 1'b1;
			repeat (4) @(posedge i_clock);
			o_sclk <= 1'b0;
		end
		repeat (4) @(posedge i_clock);
		o_cs_n <= 1'b1;
		// Released line shows no stale bit, so invert it
		o_si <= ~o_si;
		repeat (8) @(posedge i_clock);
	endtask : send
endmodule : spi_host_model

/* tb/tb.sv */
// Self-checking bench for the quad switch command decoder
`timescale 1ns/1ps
module tb;
	import switch_cmd_pkg::*;
	typedef struct packed {
		logic [1:0] os;
		logic [2:0] rs;
		logic [8:0] d;
	} row_t;
	logic i_clock = 1'b0;
	logic i_reset_n = 1'b0;
	logic sclk, cs_n, si, wd = 1'b0;
	logic [3:0] i_direct_in = 4'h0;
	logic [3:0] i_overload_off = 4'h0;
	supply_t i_supply = SUPPLY_RESET;
	logic [3:0] o_switched_outputs;
	logic [3:0][8:0] o_duty_cfg, o_switching_cfg, o_fault_cfg, o_overcurrent_cfg;
	logic [8:0] o_global_cfg, o_calibration_cfg, o_readout_select;
	logic o_readout_strobe, o_watchdog_toggle_bit, o_temp_prewarn_flag, o_undervoltage_flag;
	int miscompares = 0;
	int n_checks = 0;
	int n_strobe = 0;
	int cycles = 0;
	int s0;
	row_t rows [10] = '{
		'{2'h0, SEL_DUTY, 9'h17F}, '{2'h1, SEL_DUTY, 9'h080}, '{2'h2, SEL_DUTY, 9'h001},
		'{2'h3, SEL_DUTY, 9'h155}, '{2'h3, SEL_SWITCH, 9'h03F}, '{2'h2, SEL_FAULT, 9'h07F},
		'{2'h1, SEL_OVERCURRENT, 9'h1FF}, '{2'h0, SEL_GLOBAL, 9'h0A5}, '{2'h0, SEL_CAL, 9'h15B}, // Fixed pattern
		'{2'h2, SEL_STATUS, 9'h011}};

	always #2.5 i_clock = ~i_clock;

	spi_host_model spi_host_model_inst (.i_clock(i_clock), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));

	quad_switch_spi_command_decoder quad_switch_spi_command_decoder_inst (
		.i_clock(i_clock), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
		.i_direct_in(i_direct_in), .i_overload_off(i_overload_off), .i_supply(i_supply),
		.o_switched_outputs(o_switched_outputs), .o_duty_cfg(o_duty_cfg),
		.o_switching_cfg(o_switching_cfg), .o_fault_cfg(o_fault_cfg),
		.o_overcurrent_cfg(o_overcurrent_cfg), .o_global_cfg(o_global_cfg),
		.o_calibration_cfg(o_calibration_cfg), .o_readout_select(o_readout_select),
		.o_readout_strobe(o_readout_strobe), .o_watchdog_toggle_bit(o_watchdog_toggle_bit),
		.o_temp_prewarn_flag(o_temp_prewarn_flag), .o_undervoltage_flag(o_undervoltage_flag));

	// ==========================================
	// Strobe counter and hang guard; a run needs about 2900 cycles
	always @(posedge i_clock) begin
		cycles++;
		if (o_readout_strobe === 1'b1)
			n_strobe++;
		if (cycles == 30000) begin
			miscompares++;
			$display("MISMATCH at %0t: run did not finish", $time);
			test_done();
		end
	end

	// ==========================================
	// Command word with watchdog toggled each time and spare bit low
	function automatic logic [15:0] cmd(input logic [1:0] os, input logic [2:0] rs, input logic [8:0] d);
		wd = ~wd;
		return {wd, os, rs, 1'b0, d};
	endfunction : cmd

	// Register port that a select pair should land in
	function automatic logic [8:0] cfg_of(input logic [2:0] rs, input logic [1:0] os);
		case (rs)
			SEL_DUTY: return o_duty_cfg[os];
			SEL_SWITCH: return o_switching_cfg[os];
			SEL_FAULT: return o_fault_cfg[os];
			SEL_OVERCURRENT: return o_overcurrent_cfg[os];
			SEL_GLOBAL: return o_global_cfg;
			SEL_STATUS: return o_readout_select;
			default: return o_calibration_cfg;
		endcase
	endfunction : cfg_of

	task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Let the edge's updates land before looking
	task automatic settle(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : settle

	task automatic wr(input logic [1:0] os, input logic [2:0] rs, input logic [8:0] d);
		spi_host_model_inst.send({16'h0000, cmd(os, rs, d)}, 16);
	endtask : wr

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	// ==========================================
	// Main sequence
	initial begin
		repeat (12) @(posedge i_clock);
		i_reset_n <= 1'b1;
		settle(3);
		chk(o_duty_cfg, '0, "reset duty");
		chk(o_global_cfg, '0, "reset global");
		$display("reset test done");
		// Every select code, every output, then no cross-writes
		foreach (rows[i]) begin
			wr(rows[i].os, rows[i].rs, rows[i].d);
			settle(1);
			chk(cfg_of(rows[i].rs, rows[i].os), rows[i].d, "register write");
			chk(o_watchdog_toggle_bit, wd, "watchdog bit");
		end
		foreach (rows[i])
			chk(cfg_of(rows[i].rs, rows[i].os), rows[i].d, "register kept");
		$display("table test done");
		// Ragged frames leave the duty register of output 3 alone
		spi_host_model_inst.send(32'h0000_6400, 15);
		spi_host_model_inst.send(32'h0000_6400, 17);
		settle(1);
		chk(o_duty_cfg[3], 9'h155, "ragged frame");
		spi_host_model_inst.send({cmd(2'h1, SEL_DUTY, 9'h033), cmd(2'h1, SEL_DUTY, 9'h044)}, 32);
		settle(1);
		chk(o_duty_cfg[1], 9'h044, "two words");
		$display("framing test done");
		// Prewarning latches until read out
		@(posedge i_clock);
		i_supply.overtemp_warn <= 1'b1;
		repeat (6) @(posedge i_clock);
		i_supply.overtemp_warn <= 1'b0;
		settle(6);
		chk(o_temp_prewarn_flag, 1'b1, "prewarn held");
		s0 = n_strobe;
		wr(2'h0, SEL_STATUS, 9'h001);
		settle(1);
		chk(o_temp_prewarn_flag, 1'b0, "prewarn cleared");
		chk(n_strobe, s0 + 1, "readout strobe");
		// Battery loss keeps serial features
		@(posedge i_clock);
		i_supply.battery_lost <= 1'b1;
		settle(6);
		chk(o_undervoltage_flag, 1'b1, "undervoltage");
		wr(2'h1, SEL_DUTY, 9'h0C3);
		settle(1);
		chk({o_duty_cfg[1], o_duty_cfg[0]}, {9'h0C3, 9'h17F}, "battery lost");
		@(posedge i_clock);
		i_supply.battery_lost <= 1'b0;
		wr(2'h0, SEL_STATUS, 9'h000);
		settle(1);
		chk(o_undervoltage_flag, 1'b0, "undervoltage cleared");
		$display("flag test done");
		// Clamp beats overload, ground loss beats clamp
		@(posedge i_clock);
		i_overload_off <= 4'hF;
		settle(4);
		chk(o_switched_outputs, 4'h0, "overload off");
		@(posedge i_clock);
		i_supply.battery_clamp <= 1'b1;
		settle(6);
		chk(o_switched_outputs, 4'hF, "clamp on");
		@(posedge i_clock);
		i_supply.ground_lost <= 1'b1;
		settle(6);
		chk(o_switched_outputs, 4'h0, "ground lost");
		@(posedge i_clock);
		i_supply <= SUPPLY_RESET;
		i_overload_off <= 4'h0;
		$display("output test done");
		// Logic supply failure with wipe enabled
		wr(2'h0, SEL_GLOBAL, 9'h100);
		i_supply.logic_supply_fail <= 1'b1;
		i_direct_in <= 4'hA;
		settle(6);
		chk(o_switched_outputs, 4'hA, "direct drive");
		chk(o_duty_cfg, '0, "default config");
		@(posedge i_clock);
		i_supply.logic_supply_fail <= 1'b0;
		i_direct_in <= 4'h0;
		settle(6);
		chk({o_global_cfg, o_calibration_cfg, o_duty_cfg[0]}, '0, "supply wipe");
		// Power-on of both supplies clears config and flags
		wr(2'h2, SEL_DUTY, 9'h0FF);
		i_supply.overtemp_warn <= 1'b1;
		repeat (6) @(posedge i_clock);
		i_supply <= '{default: 1'b0, both_supply_por: 1'b1};
		repeat (6) @(posedge i_clock);
		i_supply.both_supply_por <= 1'b0;
		settle(4);
		chk({o_duty_cfg[2], o_temp_prewarn_flag}, '0, "power-on wipe");
		// Reset in mid-run
		wr(2'h0, SEL_GLOBAL, 9'h0A5);
		i_reset_n <= 1'b0;
		repeat (3) @(posedge i_clock);
		i_reset_n <= 1'b1;
		settle(4);
		chk(o_global_cfg, 9'h000, "second reset");
		$display("supply test done");
		test_done();
	end
endmodule : tb
